/* File: rtl/area_bound_if.sv */
// carrier between the register bank and one area's bound calculator
`timescale 1ns/100ps
interface area_bound_if;
	logic [10:0] first_field;
	logic [10:0] limit_field;
	logic [12:0] probe_addr;
	logic [12:0] first_byte;
	logic [12:0] limit_byte;
	logic [12:0] last_byte;
	logic valid;
	logic hit;

	modport bank (
		output first_field,
		output limit_field,
		output probe_addr,
		input first_byte,
		input limit_byte,
		input last_byte,
		input valid,
		input hit
	);
	modport calc (
		input first_field,
		input limit_field,
		input probe_addr,
		output first_byte,
		output limit_byte,
		output last_byte,
		output valid,
		output hit
	);
endinterface

/* File: rtl/area_bounds_calc.sv */
// turns an area's start and end fields into byte bounds and a hit test
`timescale 1ns/100ps
module area_bounds_calc (
	area_bound_if.calc b
);
	import fifo_area_bounds_pkg::*;

	always_comb begin
		b.first_byte = {b.first_field, 2'b00};
		b.limit_byte = {b.limit_field, 2'b00};
		// last owned byte sits just below the programmed end
		b.last_byte = b.limit_byte - 13'h0001;
		// an empty, inverted or beyond-ram area owns nothing
		b.valid = (b.first_byte < b.limit_byte) && (b.limit_byte <= RAM_TOP);
		b.hit = b.valid && (b.probe_addr >= b.first_byte) && (b.probe_addr < b.limit_byte);
	end
endmodule

/* File: rtl/fifo_area_bounds_pkg.sv */
// constants shared by the area bound register bank and its bound calculator
package fifo_area_bounds_pkg;
	localparam int AXI_ADDR_W = 12;
	localparam int FIELD_W = 11;
	localparam int RAM_ADDR_W = 13;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_A3_END_HI = 8'h8e;
	localparam logic [7:0] IDX_A3_END_LO = 8'h8f;
	localparam logic [7:0] IDX_A4_START_HI = 8'h90;
	localparam logic [7:0] IDX_A4_START_LO = 8'h91;
	localparam logic [7:0] IDX_A4_END_HI = 8'h92;
	localparam logic [7:0] IDX_A4_END_LO = 8'h93;
	localparam logic [7:0] IDX_STATE_CLEAR = 8'h9f;

	localparam logic [11:0] ADDR_A3_END_HI = {2'b00, IDX_A3_END_HI, 2'b00};
	localparam logic [11:0] ADDR_A3_END_LO = {2'b00, IDX_A3_END_LO, 2'b00};
	localparam logic [11:0] ADDR_A4_START_HI = {2'b00, IDX_A4_START_HI, 2'b00};
	localparam logic [11:0] ADDR_A4_START_LO = {2'b00, IDX_A4_START_LO, 2'b00};
	localparam logic [11:0] ADDR_A4_END_HI = {2'b00, IDX_A4_END_HI, 2'b00};
	localparam logic [11:0] ADDR_A4_END_LO = {2'b00, IDX_A4_END_LO, 2'b00};
	localparam logic [11:0] ADDR_STATE_CLEAR = {2'b00, IDX_STATE_CLEAR, 2'b00};

	localparam logic [7:0] BOUND_RESET = 8'h00;
	localparam logic [7:0] HI_MASK = 8'h1f;
	localparam logic [7:0] LO_MASK = 8'hfc;
	localparam int CLR_BIT_A3 = 3;
	localparam int CLR_BIT_A4 = 4;

	localparam logic [12:0] RAM_TOP = 13'h1200;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* File: rtl/fifo_area_bounds_regs.sv */
// axi4-lite register bank for area 3 end and area 4 start/end bounds
//
// Overview of operation
// - start field is address bits 12 to 2
// - area spans start up to before end
// - ram is 4.5 KB, bounds up to 0x1200
// - bound bytes read/write, reset 00h, reserved zero
// - clear register write-only, self-clearing, ram untouched
`timescale 1ns/100ps
module fifo_area_bounds_regs (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [fifo_area_bounds_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [fifo_area_bounds_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [fifo_area_bounds_pkg::FIELD_W-1:0] area3_first_field,
	input wire logic [fifo_area_bounds_pkg::RAM_ADDR_W-1:0] ram_addr,
	output logic [fifo_area_bounds_pkg::RAM_ADDR_W-1:0] area3_limit_addr,
	output logic [fifo_area_bounds_pkg::RAM_ADDR_W-1:0] area3_last_byte,
	output logic area3_valid,
	output logic area3_hit,
	output logic [fifo_area_bounds_pkg::RAM_ADDR_W-1:0] area4_first_byte_addr,
	output logic [fifo_area_bounds_pkg::RAM_ADDR_W-1:0] area4_limit_addr,
	output logic [fifo_area_bounds_pkg::RAM_ADDR_W-1:0] area4_last_byte,
	output logic area4_valid,
	output logic area4_hit,
	output logic area3_state_clear,
	output logic area4_state_clear
);
	import fifo_area_bounds_pkg::*;

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic aw_have;
		logic [11:0] awaddr;
		logic w_have;
		logic [7:0] wdata;
		logic wstrb0;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
		logic [7:0] a3_end_hi;
		logic [7:0] a3_end_lo;
		logic [7:0] a4_start_hi;
		logic [7:0] a4_start_lo;
		logic [7:0] a4_end_hi;
		logic [7:0] a4_end_lo;
		logic a3_clr;
		logic a4_clr;
		logic [12:0] a3_limit;
		logic [12:0] a3_last;
		logic a3_valid;
		logic a3_hit;
		logic [12:0] a4_first;
		logic [12:0] a4_limit;
		logic [12:0] a4_last;
		logic a4_valid;
		logic a4_hit;
	} state_t;

	localparam state_t STATE_RESET = '{
		awready: 1'b1,
		wready: 1'b1,
		arready: 1'b1,
		bresp: RESP_OKAY,
		rresp: RESP_OKAY,
		a3_end_hi: BOUND_RESET,
		a3_end_lo: BOUND_RESET,
		a4_start_hi: BOUND_RESET,
		a4_start_lo: BOUND_RESET,
		a4_end_hi: BOUND_RESET,
		a4_end_lo: BOUND_RESET,
		default: '0
	};

	state_t q;
	state_t d;

	area_bound_if a3_if ();
	area_bound_if a4_if ();

	// ****************************************
	// bound calculators
	// ****************************************
	assign a3_if.first_field = area3_first_field;
	assign a3_if.limit_field = {q.a3_end_hi[4:0], q.a3_end_lo[7:2]};
	assign a3_if.probe_addr = ram_addr;
	assign a4_if.first_field = {q.a4_start_hi[4:0], q.a4_start_lo[7:2]};
	assign a4_if.limit_field = {q.a4_end_hi[4:0], q.a4_end_lo[7:2]};
	assign a4_if.probe_addr = ram_addr;

	area_bounds_calc u_a3_calc (
		.b(a3_if.calc)
	);
	area_bounds_calc u_a4_calc (
		.b(a4_if.calc)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		d = q;
		d.a3_clr = 1'b0;
		d.a4_clr = 1'b0;

		// write channels are captured independently, in either order
		if (s_axi_awvalid && q.awready) begin
			d.aw_have = 1'b1;
			d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && q.wready) begin
			d.w_have = 1'b1;
			d.wdata = s_axi_wdata[7:0];
			d.wstrb0 = s_axi_wstrb[0];
		end
		if (s_axi_bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end

		if (d.aw_have && d.w_have && !d.bvalid) begin
			d.aw_have = 1'b0;
			d.w_have = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = RESP_OKAY;
			// only lane 0 carries a register; other lanes are ignored
			case (d.awaddr)
				ADDR_A3_END_HI: begin
					if (d.wstrb0) d.a3_end_hi = d.wdata & HI_MASK;
				end
				ADDR_A3_END_LO: begin
					if (d.wstrb0) d.a3_end_lo = d.wdata & LO_MASK;
				end
				ADDR_A4_START_HI: begin
					if (d.wstrb0) d.a4_start_hi = d.wdata & HI_MASK;
				end
				ADDR_A4_START_LO: begin
					if (d.wstrb0) d.a4_start_lo = d.wdata & LO_MASK;
				end
				ADDR_A4_END_HI: begin
					if (d.wstrb0) d.a4_end_hi = d.wdata & HI_MASK;
				end
				ADDR_A4_END_LO: begin
					if (d.wstrb0) d.a4_end_lo = d.wdata & LO_MASK;
				end
				ADDR_STATE_CLEAR: begin
					// one-cycle strobe; the ram contents are never touched here
					if (d.wstrb0) begin
						d.a3_clr = d.wdata[CLR_BIT_A3];
						d.a4_clr = d.wdata[CLR_BIT_A4];
					end
				end
				default: begin
					d.bresp = RESP_SLVERR;
				end
			endcase
		end
		// one write in flight: no new capture until the response is taken
		d.awready = !d.aw_have && !d.bvalid;
		d.wready = !d.w_have && !d.bvalid;

		if (s_axi_rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && q.arready) begin
			d.rvalid = 1'b1;
			d.rresp = RESP_OKAY;
			case (s_axi_araddr)
				ADDR_A3_END_HI: d.rdata = q.a3_end_hi;
				ADDR_A3_END_LO: d.rdata = q.a3_end_lo;
				ADDR_A4_START_HI: d.rdata = q.a4_start_hi;
				ADDR_A4_START_LO: d.rdata = q.a4_start_lo;
				ADDR_A4_END_HI: d.rdata = q.a4_end_hi;
				ADDR_A4_END_LO: d.rdata = q.a4_end_lo;
				ADDR_STATE_CLEAR: d.rdata = 8'h00;
				default: begin
					d.rdata = 8'h00;
					d.rresp = RESP_SLVERR;
				end
			endcase
		end
		d.arready = !d.rvalid;

		// bounds lag the register write by one cycle
		d.a3_limit = a3_if.limit_byte;
		d.a3_last = a3_if.last_byte;
		d.a3_valid = a3_if.valid;
		d.a3_hit = a3_if.hit;
		d.a4_first = a4_if.first_byte;
		d.a4_limit = a4_if.limit_byte;
		d.a4_last = a4_if.last_byte;
		d.a4_valid = a4_if.valid;
		d.a4_hit = a4_if.hit;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= STATE_RESET;
		end else begin
			q <= d;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign s_axi_awready = q.awready;
	assign s_axi_wready = q.wready;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = q.arready;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = {24'h000000, q.rdata};
	assign s_axi_rresp = q.rresp;
	assign area3_limit_addr = q.a3_limit;
	assign area3_last_byte = q.a3_last;
	assign area3_valid = q.a3_valid;
	assign area3_hit = q.a3_hit;
	assign area4_first_byte_addr = q.a4_first;
	assign area4_limit_addr = q.a4_limit;
	assign area4_last_byte = q.a4_last;
	assign area4_valid = q.a4_valid;
	assign area4_hit = q.a4_hit;
	assign area3_state_clear = q.a3_clr;
	assign area4_state_clear = q.a4_clr;
endmodule

/* File: tb/area3_start_src.sv */
// stand-in for the neighbouring bank holding the area3 start field
`timescale 1ns/100ps
module area3_start_src (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [10:0] want,
	output logic [10:0] area3_first_field
);
	// word granular, cleared by the common reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			area3_first_field <= 11'h0;
		end else begin
			area3_first_field <= want;
		end
	end
endmodule

/* File: tb/fab_monitor.sv */
// assertions on the area bound register bank ports
`timescale 1ns/100ps
module fab_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_bvalid,
	input wire logic area3_state_clear,
	input wire logic area4_state_clear,
	input wire logic area3_hit,
	input wire logic area3_valid,
	input wire logic area4_valid,
	input wire logic [12:0] area4_first_byte_addr,
	input wire logic [12:0] area4_limit_addr,
	input wire logic [12:0] area4_last_byte
);
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	chk_clr3_pulse: assert property
		(area3_state_clear |-> $rose(s_axi_bvalid) ##1 !area3_state_clear) else $error("bad area3 clear");
	chk_clr4_pulse: assert property
		(area4_state_clear |-> $rose(s_axi_bvalid) ##1 !area4_state_clear) else $error("bad area4 clear");
	chk_hit_needs_valid: assert property
		(area3_hit |-> area3_valid) else $error("hit outside valid area");
	chk_last_byte: assert property
		(area4_valid |-> area4_last_byte == area4_limit_addr - 13'h1) else $error("bad last byte");
	chk_top_bound: assert property
		(area4_valid |-> area4_limit_addr <= 13'h1200 && area4_first_byte_addr < area4_limit_addr)
		else $error("valid beyond ram");
	chk_word_align: assert property
		(area4_first_byte_addr[1:0] == 2'h0 && area4_limit_addr[1:0] == 2'h0) else $error("unaligned");
	chk_read_lat: assert property
		(s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read");
	chk_rdata_zero: assert property
		(s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
endmodule
bind fifo_area_bounds_regs fab_monitor u_mon (.*);

/* File: tb/fifo_area_bounds_regs_test.sv */
// self-checking bench for the area bound register bank
`timescale 1ns/100ps
module fifo_area_bounds_regs_test;
	import fifo_area_bounds_pkg::*;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [31:0] s_axi_rdata, q;
	logic [10:0] want = 11'h0;
	logic [10:0] area3_first_field;
	logic [12:0] ram_addr = 13'h0;
	logic [12:0] area3_limit_addr, area3_last_byte, area4_first_byte_addr, area4_limit_addr, area4_last_byte;
	logic area3_valid, area3_hit, area4_valid, area4_hit, area3_state_clear, area4_state_clear;
	int fail_count = 0, checked = 0, n3 = 0, n4 = 0;
	logic [11:0] regs [6] = '{ADDR_A3_END_HI, ADDR_A3_END_LO, ADDR_A4_START_HI, ADDR_A4_START_LO,
		ADDR_A4_END_HI, ADDR_A4_END_LO};
	logic [7:0] msk [6] = '{HI_MASK, LO_MASK, HI_MASK, LO_MASK, HI_MASK, LO_MASK};
	always #4 aclk = ~aclk;
	always @(posedge aclk) begin
		if (area3_state_clear === 1'h1) n3 <= n3 + 1;
		if (area4_state_clear === 1'h1) n4 <= n4 + 1;
	end
	fifo_area_bounds_regs u_dut (.*);
	area3_start_src u_src (.*);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test;
		$display("compares %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// *****************
	// bus master
	// *****************
	task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
		logic done;
		done = 1'h0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w;
		for (int n = 0; n < 40 && !done; n++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_bready && s_axi_bvalid) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'h0;
				done = 1'h1;
			end
			if (s_axi_rready && s_axi_rvalid) begin
				r = s_axi_rresp;
				q = s_axi_rdata;
				s_axi_rready <= 1'h0;
				done = 1'h1;
			end
		end
		if (!done) begin
			fail_count++;
			finish_test();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		bus(1'h1, a, d);
		chk({30'h0, r}, {30'h0, er});
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
		bus(1'h0, a, 8'h0);
		chk(q, {24'h0, e});
		chk({30'h0, r}, {30'h0, er});
	endtask
	task automatic set4(input logic [12:0] f, input logic [12:0] l);
		wr(ADDR_A4_START_HI, {3'h0, f[12:8]}, RESP_OKAY);
		wr(ADDR_A4_START_LO, {f[7:2], 2'h0}, RESP_OKAY);
		wr(ADDR_A4_END_HI, {3'h0, l[12:8]}, RESP_OKAY);
		wr(ADDR_A4_END_LO, {l[7:2], 2'h0}, RESP_OKAY);
		wr(ADDR_STATE_CLEAR, 8'h10, RESP_OKAY);
	endtask
	// derived outputs lag one cycle behind the probe address
	task automatic probe(input logic [12:0] a, input logic s, input logic h);
		ram_addr <= a;
		repeat (3) @(posedge aclk);
		chk({31'h0, s ? area3_hit : area4_hit}, {31'h0, h});
	endtask
	task automatic t_regs;
		for (int i = 0; i < 6; i++) begin
			rd(regs[i], BOUND_RESET, RESP_OKAY);
			wr(regs[i], 8'hff, RESP_OKAY);
			rd(regs[i], msk[i], RESP_OKAY);
		end
		// lane 0 not strobed: the register must keep its value
		s_axi_wstrb <= 4'he;
		wr(ADDR_A4_START_HI, 8'h00, RESP_OKAY);
		s_axi_wstrb <= 4'h1;
		rd(ADDR_A4_START_HI, HI_MASK, RESP_OKAY);
		rd(12'h300, 8'h0, RESP_SLVERR);
		wr(12'h300, 8'h5a, RESP_SLVERR);
		rd(ADDR_STATE_CLEAR, 8'h0, RESP_OKAY);
		chk({19'h0, area4_limit_addr}, 32'h1ffc);
		chk({31'h0, area4_valid}, 32'h0);
		$display("done regs");
	endtask
	task automatic t_area4;
		int b3, b4;
		b3 = n3;
		b4 = n4;
		set4(13'h0100, 13'h0200);
		// pulse counter only updates at the edge after the pulse is seen
		@(posedge aclk);
		chk(n4 - b4, 1);
		chk(n3 - b3, 0);
		chk({19'h0, area4_first_byte_addr}, 32'h100);
		chk({19'h0, area4_last_byte}, 32'h1ff);
		probe(13'h00ff, 1'h0, 1'h0);
		probe(13'h0100, 1'h0, 1'h1);
		probe(13'h01ff, 1'h0, 1'h1);
		probe(13'h0200, 1'h0, 1'h0);
		set4(13'h1000, 13'h1200);
		probe(13'h11ff, 1'h0, 1'h1);
		set4(13'h1000, 13'h1204);
		probe(13'h1000, 1'h0, 1'h0);
		rd(ADDR_A4_END_LO, 8'h04, RESP_OKAY);
		$display("done area4");
	endtask
	task automatic t_area3;
		int b3;
		b3 = n3;
		want <= 11'h0c0;
		wr(ADDR_A3_END_HI, 8'h04, RESP_OKAY);
		wr(ADDR_A3_END_LO, 8'h00, RESP_OKAY);
		wr(ADDR_STATE_CLEAR, 8'h08, RESP_OKAY);
		@(posedge aclk);
		chk(n3 - b3, 1);
		chk({19'h0, area3_last_byte}, 32'h3ff);
		chk({19'h0, area3_limit_addr}, 32'h400);
		chk({31'h0, area3_valid}, 32'h1);
		probe(13'h03fc, 1'h1, 1'h1);
		probe(13'h0400, 1'h1, 1'h0);
		probe(13'h02fc, 1'h1, 1'h0);
		$display("done area3");
	endtask
	// mid-run reset must bring programmed bounds back to zero
	task automatic t_reset;
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		rd(ADDR_A4_END_LO, BOUND_RESET, RESP_OKAY);
		rd(ADDR_A3_END_HI, BOUND_RESET, RESP_OKAY);
		chk({31'h0, area3_valid}, 32'h0);
		chk({19'h0, area3_limit_addr}, 32'h0);
		$display("done reset");
	endtask
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		t_regs();
		t_area4();
		t_area3();
		t_reset();
		finish_test();
	end
endmodule
